// >>> design/ipd_pkg.sv
// shared constants for the interrupt polarity and debounce block
`default_nettype none
package ipd_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IPD_IDX_STATUS   = 8'h7f;
    localparam logic [7:0]  IPD_IDX_MASK     = 8'h80;
    localparam logic [7:0]  IPD_IDX_POLARITY = 8'h81;
    localparam logic [7:0]  IPD_IDX_DEBOUNCE = 8'h82;
    localparam logic [7:0]  IPD_IDX_CLEAR    = 8'h83;
    localparam logic [7:0]  IPD_IDX_ENABLE   = 8'h84;
    localparam logic [7:0]  IPD_IDX_RAWSRC   = 8'h85;
    localparam int          IPD_ADDR_W       = 10;
    localparam int          IPD_NSRC         = 8;
    // bit positions of the sources and of the combined status bit
    localparam int          IPD_BIT_DET      = 0;
    localparam int          IPD_BIT_SHRT     = 1;
    localparam int          IPD_BIT_LOCK     = 2;
    localparam int          IPD_BIT_IN7      = 3;
    localparam int          IPD_BIT_IN8      = 4;
    localparam int          IPD_BIT_PIN1     = 5;
    localparam int          IPD_BIT_SEQ      = 8;
    localparam int          IPD_BIT_PIN4     = 9;
    localparam int          IPD_BIT_IRQ      = 10;
    localparam logic [15:0] IPD_SRC_MASK     = 16'h033f;
    localparam logic [15:0] IPD_MASK_RESET   = 16'h033f;
    localparam logic [15:0] IPD_POL_RESET    = 16'h0000;
    localparam logic [15:0] IPD_DB_RESET     = 16'h0000;
    localparam logic [1:0]  IPD_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  IPD_RESP_SLVERR  = 2'b10;
    // debounce hold time
    localparam int          IPD_DB_TIME_NS   = 400;
    localparam int          IPD_CLK_NS       = 40;
    localparam int          IPD_DB_CYCLES    = IPD_DB_TIME_NS / IPD_CLK_NS;
endpackage
`default_nettype wire

// >>> design/ipd_debounce.sv
// one-source polarity select and optional debounce filter
`timescale 1ns/1ps
`default_nettype none
module ipd_debounce #(
    parameter int HOLD = 10
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic raw,
    input  wire logic active_low,
    input  wire logic db_en,
    output logic      qualified
);
    localparam int CW = $clog2(HOLD + 1);
    if (HOLD < 1)
    begin : g_bad_hold
        $error("HOLD must be at least 1");
    end

    typedef struct packed {
        logic          stable;
        logic [CW-1:0] cnt;
    } ipd_db_s;

    ipd_db_s st;
    ipd_db_s next_st;
    logic    level;

    always_comb
    begin
        level   = raw ^ active_low;
        next_st = st;
        if (level == st.stable)
        begin
            next_st.cnt = '0;
        end
        else if (st.cnt == CW'(HOLD - 1))
        begin
            next_st.stable = level;
            next_st.cnt    = '0;
        end
        else
        begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    // filter only when enabled; bypass otherwise
    assign qualified = db_en ? st.stable : level;
endmodule
`default_nettype wire

// >>> design/ipd_top.sv
// interrupt source polarity, debounce, sticky flags and axi4-lite slave
//
// Functional notes
// - sequencer source fires while busy at polarity 0, while idle at 1.
// - lock source fires when locked at polarity 0, when unlocked at 1.
// - pin and bias sources active high at polarity 0, low at 1.
// - sequencer, lock, pin and input sources debounced only when debounce bit set.
// - bias short and detect sources debounced only when their bits set.
// - flag sets on rising edge of qualified condition, stays until software writes one.
// - combined status bit is the or of all source flags.
// - mask bits reset to one; one masks source from combined interrupt.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ipd_top
    import ipd_pkg::*;
#(
    parameter int DB_CYCLES = ipd_pkg::IPD_DB_CYCLES
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [ipd_pkg::IPD_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ipd_pkg::IPD_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          control_sequencer_busy,
    input  wire logic                          freq_locked_loop_lock,
    input  wire logic                          general_pin_four,
    input  wire logic                          general_pin_one,
    input  wire logic                          general_input_eight,
    input  wire logic                          general_input_seven,
    input  wire logic                          mic_bias_supply_short,
    input  wire logic                          mic_bias_supply_detect,
    output logic                               irq_combined,
    output logic                               irq
);
    import ipd_pkg::*;

    if (DB_CYCLES < 1)
    begin : g_bad_cycles
        $error("DB_CYCLES must be at least 1");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  aw_idx;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] polarity;
        logic [15:0] debounce;
        logic [15:0] mask;
        logic [15:0] enable;
        logic [15:0] flags;
        logic [15:0] qual_d;
        logic        irq_combined;
        logic        irq;
    } ipd_top_s;

    ipd_top_s st;
    ipd_top_s next_st;

    // ------------------------------------------------------------
    // source qualification
    // ------------------------------------------------------------
    logic [15:0] raw_src;
    logic [15:0] qual;

    always_comb
    begin
        raw_src               = '0;
        raw_src[IPD_BIT_SEQ]  = control_sequencer_busy;
        raw_src[IPD_BIT_LOCK] = freq_locked_loop_lock;
        raw_src[IPD_BIT_PIN4] = general_pin_four;
        raw_src[IPD_BIT_PIN1] = general_pin_one;
        raw_src[IPD_BIT_IN8]  = general_input_eight;
        raw_src[IPD_BIT_IN7]  = general_input_seven;
        raw_src[IPD_BIT_SHRT] = mic_bias_supply_short;
        raw_src[IPD_BIT_DET]  = mic_bias_supply_detect;
    end

    // polarity xor then filter, one instance per source bit position
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_src
            if (IPD_SRC_MASK[g])
            begin : g_on
                ipd_debounce #(
                    .HOLD (DB_CYCLES)
                ) u_db (
                    .aclk       (aclk),
                    .aresetn    (aresetn),
                    .raw        (raw_src[g]),
                    .active_low (st.polarity[g]),
                    .db_en      (st.debounce[g]),
                    .qualified  (qual[g])
                );
            end
            else
            begin : g_off
                assign qual[g] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // bus and register logic
    // ------------------------------------------------------------
    logic        wr_fire;
    logic [15:0] wr_val;
    logic [15:0] clr_bits;
    logic [15:0] set_bits;
    logic [7:0]  ar_idx;
    logic [15:0] status_rd;

    always_comb
    begin
        next_st  = st;
        wr_fire  = st.aw_held && st.w_held && !st.bvalid;
        wr_val   = st.wdata[15:0];
        if (!st.wstrb[0])
            wr_val[7:0] = 8'h00;
        if (!st.wstrb[1])
            wr_val[15:8] = 8'h00;
        clr_bits = '0;
        // rising edge of qualified condition sets the flag
        // edge, not level: a held source would re-raise a cleared flag
        set_bits = qual & ~st.qual_d & IPD_SRC_MASK;
        next_st.qual_d = qual;

        // address and data taken independently
        // ready stays low until the response handshake: one write at a time
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx  = s_axi_awaddr[IPD_ADDR_W-1:2];
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
            next_st.wready = 1'b0;
        end

        if (wr_fire)
        begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = IPD_RESP_OKAY;
            unique case (st.aw_idx)
                IPD_IDX_MASK:     next_st.mask     = wr_val & IPD_SRC_MASK;
                IPD_IDX_POLARITY: next_st.polarity = wr_val & IPD_SRC_MASK;
                IPD_IDX_DEBOUNCE: next_st.debounce = wr_val & IPD_SRC_MASK;
                IPD_IDX_ENABLE:   next_st.enable   = wr_val & IPD_SRC_MASK;
                // write one to clear, at status or the clear register
                IPD_IDX_STATUS,
                IPD_IDX_CLEAR:    clr_bits         = wr_val & IPD_SRC_MASK;
                IPD_IDX_RAWSRC:   next_st.bresp    = IPD_RESP_OKAY;
                default:          next_st.bresp    = IPD_RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid  = 1'b0;
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // set wins over a clear in the same cycle
        next_st.flags = (st.flags & ~clr_bits) | set_bits;

        // read: address taken, data one cycle later
        // registers are 16 bits; upper half of rdata reads zero
        ar_idx    = s_axi_araddr[IPD_ADDR_W-1:2];
        status_rd = st.flags;
        status_rd[IPD_BIT_IRQ] = |st.flags;
        if (s_axi_arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = IPD_RESP_OKAY;
            next_st.rdata   = '0;
            unique case (ar_idx)
                // sequencer flag is unreliable while busy; software's concern
                IPD_IDX_STATUS:   next_st.rdata[15:0] = status_rd;
                IPD_IDX_MASK:     next_st.rdata[15:0] = st.mask;
                IPD_IDX_POLARITY: next_st.rdata[15:0] = st.polarity;
                IPD_IDX_DEBOUNCE: next_st.rdata[15:0] = st.debounce;
                IPD_IDX_ENABLE:   next_st.rdata[15:0] = st.enable;
                IPD_IDX_RAWSRC:   next_st.rdata[15:0] = qual;
                IPD_IDX_CLEAR:    next_st.rdata       = '0;
                default:          next_st.rresp       = IPD_RESP_SLVERR;
            endcase
        end
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        // combined output ignores masked sources
        // irq follows the enable register, independent of the mask
        next_st.irq_combined = |(st.flags & ~st.mask);
        next_st.irq          = |(st.flags & st.enable);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st          <= '0;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
            st.mask     <= IPD_MASK_RESET;
            st.polarity <= IPD_POL_RESET;
            st.debounce <= IPD_DB_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign irq_combined  = st.irq_combined;
    assign irq           = st.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_seq_busy_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(qual[IPD_BIT_SEQ]) |=> st.flags[IPD_BIT_SEQ])
        else $error("sequencer flag not set on qualified edge");
    a_lock_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st.debounce[IPD_BIT_LOCK] && $stable(st.polarity[IPD_BIT_LOCK]))
        |-> qual[IPD_BIT_LOCK] == (freq_locked_loop_lock ^ st.polarity[IPD_BIT_LOCK]))
        else $error("lock source polarity wrong");
    a_pin_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.debounce[IPD_BIT_PIN1]
        |-> qual[IPD_BIT_PIN1] == (general_pin_one ^ st.polarity[IPD_BIT_PIN1]))
        else $error("pin one polarity wrong");
    a_db_holds_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.debounce[IPD_BIT_IN7] && $past(st.debounce[IPD_BIT_IN7])
         && $changed(qual[IPD_BIT_IN7]))
        |-> qual[IPD_BIT_IN7]
            == ($past(general_input_seven) ^ $past(st.polarity[IPD_BIT_IN7])))
        else $error("debounced input changed at once");
    a_bias_db_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.debounce[IPD_BIT_DET]
        |-> qual[IPD_BIT_DET] == (mic_bias_supply_detect ^ st.polarity[IPD_BIT_DET]))
        else $error("undebounced bias detect not passed through");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (st.flags[IPD_BIT_PIN4] && !(wr_fire && clr_bits[IPD_BIT_PIN4]))
        |=> st.flags[IPD_BIT_PIN4])
        else $error("flag dropped without a clear");
    a_combined_or: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && st.arready && ar_idx == IPD_IDX_STATUS)
        |=> st.rdata[IPD_BIT_IRQ] == ($past(st.flags) != 16'h0000))
        else $error("combined status bit wrong");
    a_mask_gates: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 irq_combined == |($past(st.flags) & ~$past(st.mask)))
        else $error("masked combined interrupt wrong");
endmodule
`default_nettype wire

// >>> testbench/ipd_host_model.sv
// host side model watching the irq output
`timescale 1ns/1ps
`default_nettype none
module ipd_host_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic irq,
    input  wire logic seq_busy,
    output int        n_rise,
    output logic      seq_flag_valid
);
    logic irq_d;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_d  <= 1'b0;
            n_rise <= 0;
        end
        else
        begin
            irq_d <= irq;
            if (irq && !irq_d)
                n_rise <= n_rise + 1;
        end
    end
    // the sequencer flag reads back garbage while busy, so trust it only when idle
    assign seq_flag_valid = !seq_busy;
endmodule
`default_nettype wire

// >>> testbench/ipd_top_test.sv
// self-checking bench for the interrupt polarity and debounce block
`timescale 1ns/1ps
`default_nettype none
module ipd_top_test;
    import ipd_pkg::*;
    localparam int          M = 32'h033f;
    logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        [9:0]      awaddr, araddr;
    logic        [31:0]     wdata, rd_v;
    logic        [3:0]      wstrb;
    logic        [15:0]     raw;
    logic        [1:0]      rs;
    wire logic              awready, wready, bvalid, arready, rvalid, irq_c, irq, seq_ok;
    wire logic   [1:0]      bresp, rresp;
    wire logic   [31:0]     rdata;
    int                     n_mismatch, samples_checked, n_rise, n0;
    int                     pol, db, msk, en, flg, qp, c;

    ipd_top #(.DB_CYCLES(2)) u_ipd_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .control_sequencer_busy(raw[IPD_BIT_SEQ]), .freq_locked_loop_lock(raw[IPD_BIT_LOCK]),
        .general_pin_four(raw[IPD_BIT_PIN4]), .general_pin_one(raw[IPD_BIT_PIN1]),
        .general_input_eight(raw[IPD_BIT_IN8]), .general_input_seven(raw[IPD_BIT_IN7]),
        .mic_bias_supply_short(raw[IPD_BIT_SHRT]), .mic_bias_supply_detect(raw[IPD_BIT_DET]),
        .irq_combined(irq_c), .irq(irq));
    ipd_host_model u_ipd_host_model (.aclk(aclk), .aresetn(aresetn), .irq(irq),
        .seq_busy(raw[IPD_BIT_SEQ]), .n_rise(n_rise), .seq_flag_valid(seq_ok));

    // --------------------------------------------------
    // shared tasks
    // --------------------------------------------------
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        bit bd;
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        bd = 0;
        while (!bd)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                rs = bresp;
                bready <= 1'b0;
                bd = 1;
            end
        end
    endtask
    task automatic rd(input logic [7:0] idx);
        bit bd;
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        bd = 0;
        while (!bd)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                rd_v = rdata;
                rs = rresp;
                rready <= 1'b0;
                bd = 1;
            end
        end
    endtask
    // model: a flag sets on each rise of the settled qualified level
    task automatic settle();
        int q;
        cyc(8);
        q = (raw ^ pol) & M;
        flg = flg | (q & ~qp);
        qp = q;
    endtask
    task automatic chk_all();
        logic [31:0] vm;
        vm = seq_ok ? 32'hffff : 32'hfeff;
        rd(IPD_IDX_RAWSRC);
        chk(rd_v, (raw ^ pol) & M);
        rd(IPD_IDX_STATUS);
        chk(rd_v & vm, (flg | ((flg != 0) ? 32'h400 : 32'h0)) & vm);
        chk({31'h0, irq_c}, ((flg & ~msk) != 0) ? 32'h1 : 32'h0);
        chk({31'h0, irq}, ((flg & en) != 0) ? 32'h1 : 32'h0);
    endtask

    // --------------------------------------------------
    // clock, watchdog and main sequence
    // --------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial
    begin
        #(40 * 40000);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        aresetn = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; raw = '0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        n_mismatch = 0; samples_checked = 0; pol = 0; db = 0; msk = M; en = 0;
        flg = 0; qp = 0;
        void'($urandom(47));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IPD_IDX_MASK);
        chk(rd_v, IPD_MASK_RESET);
        rd(IPD_IDX_POLARITY);
        chk(rd_v, IPD_POL_RESET);
        rd(IPD_IDX_DEBOUNCE);
        chk(rd_v, IPD_DB_RESET);
        chk_all();
        $display("test reset done");
        repeat (16)
        begin
            pol = $urandom & M;
            db = $urandom & M;
            msk = $urandom & M;
            en = $urandom & M;
            wr(IPD_IDX_POLARITY, pol[15:0]);
            chk(rs, IPD_RESP_OKAY);
            settle();
            wr(IPD_IDX_DEBOUNCE, db[15:0]);
            wr(IPD_IDX_MASK, msk[15:0]);
            wr(IPD_IDX_ENABLE, en[15:0]);
            rd(IPD_IDX_DEBOUNCE);
            chk(rd_v, db);
            raw <= 16'($urandom);
            settle();
            chk_all();
            c = $urandom & M;
            wr(c[0] ? IPD_IDX_STATUS : IPD_IDX_CLEAR, c[15:0]);
            flg = flg & ~c;
            chk_all();
        end
        $display("test random done");
        en = M;
        msk = 0;
        wr(IPD_IDX_ENABLE, en[15:0]);
        wr(IPD_IDX_MASK, 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            db = k ? 0 : M;
            wr(IPD_IDX_DEBOUNCE, db[15:0]);
            raw <= pol[15:0];
            settle();
            wr(IPD_IDX_CLEAR, M[15:0]);
            flg = 0;
            n0 = n_rise;
            raw <= ~pol[15:0];
            @(posedge aclk);
            raw <= pol[15:0];
            cyc(8);
            flg = k ? M : 0;
            chk_all();
            chk(n_rise - n0, k);
        end
        rd(IPD_IDX_CLEAR);
        chk(rd_v, 0);
        $display("test debounce done");
        wr(8'h90, 16'hffff);
        chk(rs, IPD_RESP_SLVERR);
        rd(8'h90);
        chk(rs, IPD_RESP_SLVERR);
        chk(rd_v, 0);
        $display("test unmapped done");
        wstrb <= 4'h1;
        wr(IPD_IDX_ENABLE, 16'hffff);
        rd(IPD_IDX_ENABLE);
        chk(rd_v, 32'h003f);
        wstrb <= 4'hf;
        $display("test strobe done");
        conclude();
    end
endmodule
`default_nettype wire
